// ### hdl/la_capture_defines.svh
// Constants shared by the capture engine, its buffer and its upload queue
`ifndef LA_CAPTURE_DEFINES_SVH
`define LA_CAPTURE_DEFINES_SVH

// log2 of the largest capture buffer, fixed when the core is built
`define LA_MAX_DEPTH_LOG2 10
// Width of a probe sample
`define LA_PROBE_W 8
// Number of advanced trigger flags
`define LA_FLAG_W 4
// Width of the advanced trigger state code
`define LA_TSTATE_W 4
// Depth of the upload queue, in words
`define LA_FIFO_DEPTH 16
// Value of a one-step increment
`define LA_ONE 1

`endif

// ### hdl/la_capture_pkg.sv
// Types shared by the capture engine and its users
package la_capture_pkg;
  `include "la_capture_defines.svh"

  typedef enum logic [2:0] {
    stIdle,
    stPreTrigger,
    stWaitTrigger,
    stPostTrigger,
    stFull
  } coreState_t;

  typedef struct packed {
    logic [`LA_MAX_DEPTH_LOG2-1:0] windowIndex;
    logic [`LA_MAX_DEPTH_LOG2:0] windowSamples;
    logic [`LA_MAX_DEPTH_LOG2:0] totalSamples;
  } captureStatus_t;

  typedef struct packed {
    logic [`LA_FLAG_W-1:0] flags;
    logic [`LA_TSTATE_W-1:0] trigState;
  } advStatus_t;

  typedef struct packed {
    logic triggerMark;
    logic [`LA_PROBE_W-1:0] sample;
  } uploadWord_t;
endpackage : la_capture_pkg

// ### hdl/capture_ram.sv
// Capture sample memory: one write port, one registered read port
`timescale 1ns/1ps
module capture_ram #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 10
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic rdEn,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] mem [2**ADDR_W];

  // No reset: contents are only meaningful once written
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : capture_ram

// ### hdl/upload_fifo.sv
// Upload queue between the capture buffer and the host
`timescale 1ns/1ps
`include "la_capture_defines.svh"
module upload_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wrPtr;
  logic [PW:0] rdPtr;
  logic [PW:0] next_wrPtr;
  logic [PW:0] next_rdPtr;
  logic push;
  logic pop;

  always_comb begin
    inReady = (wrPtr - rdPtr) != (PW+1)'(DEPTH);
    outValid = wrPtr != rdPtr;
    push = inValid && inReady;
    pop = outValid && outReady;
    next_wrPtr = push ? wrPtr + (PW+1)'(`LA_ONE) : wrPtr;
    next_rdPtr = pop ? rdPtr + (PW+1)'(`LA_ONE) : rdPtr;
    outData = mem[rdPtr[PW-1:0]];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
    if (push) begin
      mem[wrPtr[PW-1:0]] <= inData;
    end
  end
endmodule : upload_fifo

// ### hdl/logic_analyzer_capture_engine.sv
// Trigger and capture controller of an embedded logic analyzer
//
// What this block does
// R1: Trigger position is any index in window.
// R2: Window depth is any power of two up to the 1024-sample buffer.
// R3: Normal run arms and waits for trigger.
// R4: Immediate run arms and triggers at once.
// R5: Stop halts any capture in progress.
// R6: Core re-arms itself after upload when rearm enabled and no stop came since the run.
// R7: Full core stays unarmed until upload ends.
// R8: Run from idle: wait or pre-trigger by position.
// R9: Pre-trigger stores up to position, then waits.
// R10: Trigger at last position ends window; full if last window.
// R11: Post-trigger fills rest of window, then next window or full.
// R12: Full holds data until upload completes, then idle or re-armed.
// R13: Stop exposes every completely filled window.
// R14: Stop exposes partial window only if triggered.
// R15: Window, window count, total reported; zero in idle.
// R16: Advanced mode shows the four trigger flags.
// R17: Advanced waiting shows trigger state machine state.
// R19: Reported status items depend on trigger mode.
// R20: Buffer split into equal windows with marks.
// R21: Position zero re-arms cycle after window end.
// R22: Everything on probed clock, one sample per cycle.
// R23: Stop returns to idle or full, no further writes.
`timescale 1ns/1ps
`include "la_capture_defines.svh"
module logic_analyzer_capture_engine #(
  parameter int DATA_W = `LA_PROBE_W,
  parameter int FIFO_DEPTH = `LA_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [DATA_W-1:0] probeData,
  input wire logic triggerHit,
  input wire logic runCmd,
  input wire logic runImmediateCmd,
  input wire logic stopCmd,
  input wire logic automatic_rearm,
  input wire logic advancedMode,
  input wire logic [`LA_FLAG_W-1:0] advFlags,
  input wire logic [`LA_TSTATE_W-1:0] advTrigState,
  input wire logic [$clog2(`LA_MAX_DEPTH_LOG2+1)-1:0] depthLog2,
  input wire logic [$clog2(`LA_MAX_DEPTH_LOG2+1)-1:0] windowsLog2,
  input wire logic [`LA_MAX_DEPTH_LOG2-1:0] triggerPosition,
  output la_capture_pkg::coreState_t coreStatus,
  output la_capture_pkg::captureStatus_t captureStatus,
  output la_capture_pkg::advStatus_t advStatus,
  output logic [`LA_MAX_DEPTH_LOG2:0] uploadWindows,
  output logic uploadValid,
  input wire logic uploadReady,
  output la_capture_pkg::uploadWord_t uploadData
);
  import la_capture_pkg::*;

  localparam int AW = `LA_MAX_DEPTH_LOG2;
  localparam int CW = AW + 1;
  localparam int LW = $clog2(`LA_MAX_DEPTH_LOG2+1);
  localparam int UW = DATA_W + 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration decode

  logic [CW-1:0] depth;
  logic [CW-1:0] lastIdx;
  logic [CW-1:0] trigPos;
  logic [CW-1:0] winCount;
  logic [CW-1:0] lastWin;
  logic posZero;
  logic posLast;

  always_comb begin
    // R2 power-of-two depth
    depth = CW'(`LA_ONE) << depthLog2;
    lastIdx = depth - CW'(`LA_ONE);
    // R1 position folded into window
    trigPos = CW'(triggerPosition) & lastIdx;
    // R20 equal windows
    winCount = CW'(`LA_ONE) << windowsLog2;
    lastWin = winCount - CW'(`LA_ONE);
    posZero = trigPos == '0;
    posLast = trigPos == lastIdx;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Capture state

  coreState_t state;
  coreState_t next_state;
  logic [CW-1:0] win;
  logic [CW-1:0] next_win;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] total;
  logic [CW-1:0] next_total;
  logic trigSeen;
  logic next_trigSeen;
  logic immActive;
  logic next_immActive;
  logic stopSeen;
  logic next_stopSeen;
  logic [CW-1:0] upWins;
  logic [CW-1:0] next_upWins;
  logic [CW-1:0] tailLen;
  logic [CW-1:0] next_tailLen;
  logic wrEn;
  logic fire;
  logic uploadDone;

  always_comb begin
    next_state = state;
    next_win = win;
    next_cnt = cnt;
    next_total = total;
    next_trigSeen = trigSeen;
    next_immActive = immActive;
    next_stopSeen = stopSeen;
    next_upWins = upWins;
    next_tailLen = tailLen;
    wrEn = 1'b0;
    // R4 immediate run forces trigger
    fire = triggerHit || immActive;
    unique case (state)
      stIdle: begin
        // R15 counters cleared while idle
        next_win = '0;
        next_cnt = '0;
        next_total = '0;
        next_trigSeen = 1'b0;
        // R3 arm on run
        if (runCmd || runImmediateCmd) begin
          next_immActive = runImmediateCmd;
          next_stopSeen = 1'b0;
          // R8 choose first capture state
          next_state = posZero ? stWaitTrigger : stPreTrigger;
        end
      end
      stPreTrigger, stWaitTrigger, stPostTrigger: begin
        if (stopCmd) begin
          // R13 completed windows kept
          next_upWins = win;
          // R14 partial window only if triggered
          next_tailLen = trigSeen ? cnt : '0;
          next_stopSeen = 1'b1;
          // R5 R23 halt, no writes
          next_state = (win != '0 || (trigSeen && cnt != '0)) ? stFull : stIdle;
        end else if (state == stPreTrigger) begin
          // R9 store pre-trigger samples
          wrEn = 1'b1;
          next_cnt = cnt + CW'(`LA_ONE);
          next_total = total + CW'(`LA_ONE);
          if (next_cnt == trigPos) begin
            next_state = stWaitTrigger;
          end
        end else if (state == stWaitTrigger) begin
          if (fire) begin
            // R22 trigger sample stored this cycle
            wrEn = 1'b1;
            next_trigSeen = 1'b1;
            next_cnt = cnt + CW'(`LA_ONE);
            next_total = total + CW'(`LA_ONE);
            // R10 last position ends window
            next_state = posLast ? stFull : stPostTrigger;
          end
        end else begin
          // R11 post-trigger samples
          wrEn = 1'b1;
          next_cnt = cnt + CW'(`LA_ONE);
          next_total = total + CW'(`LA_ONE);
          next_state = (cnt == lastIdx) ? stFull : stPostTrigger;
        end
        // End of a window: next window or full buffer
        if (!stopCmd && wrEn && cnt == lastIdx) begin
          if (win == lastWin) begin
            next_upWins = winCount;
            next_tailLen = '0;
            next_state = stFull;
          end else begin
            // R21 re-armed on the very next cycle
            next_win = win + CW'(`LA_ONE);
            next_cnt = '0;
            next_trigSeen = 1'b0;
            next_state = posZero ? stWaitTrigger : stPreTrigger;
          end
        end
      end
      stFull: begin
        // R7 no arming while full
        if (stopCmd) begin
          next_stopSeen = 1'b1;
        end
        // R12 leave only when upload drained
        if (uploadDone) begin
          next_win = '0;
          next_cnt = '0;
          next_total = '0;
          next_trigSeen = 1'b0;
          if (automatic_rearm && !stopSeen && !stopCmd) begin
            // R6 re-arm with the same run kind
            next_state = posZero ? stWaitTrigger : stPreTrigger;
          end else begin
            next_state = stIdle;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= stIdle;
      win <= '0;
      cnt <= '0;
      total <= '0;
      trigSeen <= 1'b0;
      immActive <= 1'b0;
      stopSeen <= 1'b0;
      upWins <= '0;
      tailLen <= '0;
    end else begin
      state <= next_state;
      win <= next_win;
      cnt <= next_cnt;
      total <= next_total;
      trigSeen <= next_trigSeen;
      immActive <= next_immActive;
      stopSeen <= next_stopSeen;
      upWins <= next_upWins;
      tailLen <= next_tailLen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sample buffer

  logic [AW-1:0] wrAddr;
  logic [AW-1:0] rdAddr;
  logic [DATA_W-1:0] rdSample;
  logic rdIssue;
  logic [CW-1:0] rdWin;
  logic [CW-1:0] rdIdx;

  always_comb begin
    // R20 window base by shift of depth
    wrAddr = AW'((win << depthLog2) | cnt);
    rdAddr = AW'((rdWin << depthLog2) | rdIdx);
  end

  capture_ram #(
    .DATA_W(DATA_W),
    .ADDR_W(AW)
  ) sampleRam (
    .clk(clk),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(probeData),
    .rdEn(rdIssue),
    .rdAddr(rdAddr),
    .rdData(rdSample)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Upload reader

  logic [CW-1:0] next_rdWin;
  logic [CW-1:0] next_rdIdx;
  logic rdPend;
  logic next_rdPend;
  logic rdMark;
  logic next_rdMark;
  logic moreToRead;
  logic qReady;
  logic qValid;
  uploadWord_t qData;

  always_comb begin
    moreToRead = (rdWin < upWins) || (rdWin == upWins && rdIdx < tailLen);
    // Memory read only while the queue can take the word held in flight
    rdIssue = (state == stFull) && moreToRead && (!rdPend || qReady);
    next_rdWin = rdWin;
    next_rdIdx = rdIdx;
    next_rdMark = rdMark;
    next_rdPend = rdPend && !qReady;
    if (state != stFull) begin
      next_rdWin = '0;
      next_rdIdx = '0;
      next_rdPend = 1'b0;
    end else if (rdIssue) begin
      next_rdPend = 1'b1;
      // R20 mark the trigger sample of each window
      next_rdMark = rdIdx == trigPos;
      if (rdIdx == lastIdx) begin
        next_rdWin = rdWin + CW'(`LA_ONE);
        next_rdIdx = '0;
      end else begin
        next_rdIdx = rdIdx + CW'(`LA_ONE);
      end
    end
    uploadDone = !moreToRead && !rdPend && !qValid;
    qData.triggerMark = rdMark;
    qData.sample = rdSample;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdWin <= '0;
      rdIdx <= '0;
      rdPend <= 1'b0;
      rdMark <= 1'b0;
    end else begin
      rdWin <= next_rdWin;
      rdIdx <= next_rdIdx;
      rdPend <= next_rdPend;
      rdMark <= next_rdMark;
    end
  end

  upload_fifo #(
    .WIDTH(UW),
    .DEPTH(FIFO_DEPTH)
  ) uploadQueue (
    .clk(clk),
    .rst(rst),
    .inValid(rdPend),
    .inReady(qReady),
    .inData(qData),
    .outValid(qValid),
    .outReady(uploadReady),
    .outData(uploadData)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Status

  advStatus_t advReg;
  advStatus_t next_advReg;

  always_comb begin
    next_advReg = '0;
    // R19 advanced items only in advanced mode
    if (advancedMode) begin
      // R16 trigger flags
      next_advReg.flags = advFlags;
      // R17 trigger state while waiting only
      if (next_state == stWaitTrigger) begin
        next_advReg.trigState = advTrigState;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      advReg <= '0;
    end else begin
      advReg <= next_advReg;
    end
  end

  always_comb begin
    coreStatus = state;
    // R15 zero whenever idle, stop included
    captureStatus.windowIndex = (state == stIdle) ? '0 : win[AW-1:0];
    captureStatus.windowSamples = (state == stIdle) ? '0 : cnt;
    captureStatus.totalSamples = (state == stIdle) ? '0 : total;
    advStatus = advReg;
    uploadValid = qValid;
    uploadWindows = (state == stFull) ? upWins + CW'(tailLen != '0) : '0;
  end
endmodule : logic_analyzer_capture_engine

// ### tb/la_capture_props.sv
// Port-level checker of the capture engine
`timescale 1ns/1ps
`include "la_capture_defines.svh"
module la_capture_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic runCmd,
  input wire logic runImmediateCmd,
  input wire logic stopCmd,
  input wire logic triggerHit,
  input wire logic advancedMode,
  input wire logic [`LA_FLAG_W-1:0] advFlags,
  input wire logic [`LA_TSTATE_W-1:0] advTrigState,
  input wire logic [3:0] depthLog2,
  input wire logic [3:0] windowsLog2,
  input wire logic [9:0] triggerPosition,
  input wire la_capture_pkg::coreState_t coreStatus,
  input wire la_capture_pkg::captureStatus_t captureStatus,
  input wire la_capture_pkg::advStatus_t advStatus,
  input wire logic [10:0] uploadWindows,
  input wire logic uploadValid
);
  import la_capture_pkg::*;
  // Position folded into the window, as the core does
  wire [9:0] posMod = triggerPosition & ((10'h1 << depthLog2) - 10'h1);
  wire isLast = posMod == ((10'h1 << depthLog2) - 10'h1);
  wire runReq = coreStatus == stIdle && (runCmd || runImmediateCmd) && !stopCmd;
  wire armed = coreStatus inside {stPreTrigger, stWaitTrigger, stPostTrigger};
  wire hitNow = coreStatus == stWaitTrigger && triggerHit && !stopCmd;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_runWait; runReq && posMod == 10'h0 |=> coreStatus == stWaitTrigger; endproperty
  a_runWait: assert property (p_runWait) else $error("run did not wait");
  property p_runPre; runReq && posMod != 10'h0 |=> coreStatus == stPreTrigger; endproperty
  a_runPre: assert property (p_runPre) else $error("run did not pre-capture");
  property p_idleHold; coreStatus == stIdle && !runCmd && !runImmediateCmd |=> coreStatus == stIdle;
  endproperty
  a_idleHold: assert property (p_idleHold) else $error("left idle without run");
  property p_trigFull; hitNow && isLast && windowsLog2 == 4'h0 |=> coreStatus == stFull; endproperty
  a_trigFull: assert property (p_trigFull) else $error("last position not full");
  property p_trigPost; hitNow && !isLast |=> coreStatus == stPostTrigger; endproperty
  a_trigPost: assert property (p_trigPost) else $error("trigger not post");
  property p_stopHalt; armed && stopCmd |=> coreStatus inside {stIdle, stFull}; endproperty
  a_stopHalt: assert property (p_stopHalt) else $error("stop did not halt");
  property p_idleZero; coreStatus == stIdle |-> captureStatus == '0; endproperty
  a_idleZero: assert property (p_idleZero) else $error("counters not zero in idle");
  property p_uploadFull; uploadWindows != 11'h0 |-> coreStatus == stFull; endproperty
  a_uploadFull: assert property (p_uploadFull) else $error("windows outside full");
  property p_fullHold; coreStatus == stFull && uploadValid |=> coreStatus == stFull; endproperty
  a_fullHold: assert property (p_fullHold) else $error("left full during upload");
  property p_flags; !$past(rst) && $past(advancedMode) |-> advStatus.flags == $past(advFlags);
  endproperty
  a_flags: assert property (p_flags) else $error("flags not reported");
  property p_trigState;
    !$past(rst) && $past(advancedMode) && coreStatus == stWaitTrigger
      |-> advStatus.trigState == $past(advTrigState);
  endproperty
  a_trigState: assert property (p_trigState) else $error("trigger state not reported");
  property p_postStep;
    coreStatus == stPostTrigger ##1 coreStatus == stPostTrigger
      |-> captureStatus.windowSamples == $past(captureStatus.windowSamples) + 11'h1;
  endproperty
  a_postStep: assert property (p_postStep) else $error("not one sample per cycle");
endmodule : la_capture_props
bind logic_analyzer_capture_engine la_capture_props u_props (.clk, .rst, .runCmd,
  .runImmediateCmd, .stopCmd, .triggerHit, .advancedMode, .advFlags, .advTrigState,
  .depthLog2, .windowsLog2, .triggerPosition, .coreStatus, .captureStatus, .advStatus,
  .uploadWindows, .uploadValid);

// ### tb/host_upload_model.sv
// Host side model that drains the upload stream
`timescale 1ns/1ps
module host_upload_model (
  input wire logic clk,
  input wire logic clearCnt,
  input wire logic stall,
  input wire logic uploadValid,
  input wire la_capture_pkg::uploadWord_t uploadData,
  output logic uploadReady,
  output logic [15:0] wordCount,
  output logic [15:0] markCount
);
  import la_capture_pkg::*;
  logic [1:0] phase;
  always_ff @(posedge clk) begin
    phase <= clearCnt ? 2'h0 : phase + 2'h1;
    // Slow host takes one word in four
    uploadReady <= !clearCnt && (!stall || phase == 2'h3);
    if (clearCnt) begin
      wordCount <= 16'h0;
      markCount <= 16'h0;
    end else if (uploadValid && uploadReady) begin
      wordCount <= wordCount + 16'h1;
      markCount <= markCount + {15'h0, uploadData.triggerMark};
    end
  end
endmodule : host_upload_model

// ### tb/test_logic_analyzer_capture_engine.sv
// Self-checking bench of the capture engine
`timescale 1ns/1ps
module test_logic_analyzer_capture_engine;
  import la_capture_pkg::*;
  logic clk = 0, rst = 1, runCmd = 0, runImmediateCmd = 0, stopCmd = 0, triggerHit = 0;
  logic automatic_rearm = 0, advancedMode = 0, stall = 0, clearCnt = 1;
  logic [7:0] probeData = 8'h0;
  logic [3:0] advFlags = 4'h3, advTrigState = 4'h0, depthLog2 = 4'h1, windowsLog2 = 4'h0;
  logic [9:0] triggerPosition = 10'h0;
  coreState_t coreStatus;
  captureStatus_t captureStatus;
  advStatus_t advStatus;
  uploadWord_t uploadData;
  logic [10:0] uploadWindows;
  logic uploadValid, uploadReady;
  logic [15:0] wordCount, markCount;
  int error_cnt = 0, check_count = 0, cycles = 0;
  // Rows: immediate, depthLog2, windowsLog2, position, slow host, windows, words
  int rows[6][7] = '{'{0, 2, 0, 1, 0, 1, 4}, '{0, 2, 0, 3, 0, 1, 4}, '{0, 0, 0, 0, 0, 1, 1},
    '{1, 3, 2, 0, 0, 4, 32}, '{0, 2, 1, 2, 1, 2, 8}, '{0, 4, 0, 21, 1, 1, 16}};
  logic_analyzer_capture_engine dut (.clk(clk), .rst(rst), .probeData(probeData),
    .triggerHit(triggerHit), .runCmd(runCmd), .runImmediateCmd(runImmediateCmd),
    .stopCmd(stopCmd), .automatic_rearm(automatic_rearm), .advancedMode(advancedMode),
    .advFlags(advFlags), .advTrigState(advTrigState), .depthLog2(depthLog2),
    .windowsLog2(windowsLog2), .triggerPosition(triggerPosition), .coreStatus(coreStatus),
    .captureStatus(captureStatus), .advStatus(advStatus), .uploadWindows(uploadWindows),
    .uploadValid(uploadValid), .uploadReady(uploadReady), .uploadData(uploadData));
  host_upload_model u_host (.clk(clk), .clearCnt(clearCnt), .stall(stall),
    .uploadValid(uploadValid), .uploadData(uploadData), .uploadReady(uploadReady),
    .wordCount(wordCount), .markCount(markCount));
  always #2 clk = ~clk;
  always @(negedge clk) probeData <= probeData + 8'h1;
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // Hang guard well above the longest sequence
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wait_state(input coreState_t s);
    while (coreStatus !== s) @(negedge clk);
  endtask : wait_state
  task automatic clear_host();
    clearCnt = 1;
    @(negedge clk);
    clearCnt = 0;
  endtask : clear_host
  task automatic run(input logic imm);
    runImmediateCmd = imm;
    runCmd = !imm;
    @(negedge clk);
    runImmediateCmd = 0;
    runCmd = 0;
  endtask : run
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    clearCnt = 0;
    check("resetState", coreStatus, stIdle);
    check("resetCounts", captureStatus, 32'h0);
    check("resetValid", uploadValid, 1'b0);
    for (int i = 0; i < 6; i++) begin
      depthLog2 = rows[i][1][3:0];
      windowsLog2 = rows[i][2][3:0];
      triggerPosition = rows[i][3][9:0];
      stall = rows[i][4][0];
      run(rows[i][0][0]);
      repeat (3) @(negedge clk);
      triggerHit = 1;
      wait_state(stFull);
      triggerHit = 0;
      check("windows", uploadWindows, rows[i][5]);
      check("basicAdv", advStatus, 8'h0);
      wait_state(stIdle);
      check("words", wordCount, rows[i][6]);
      check("marks", markCount, rows[i][5]);
      clear_host();
    end
    // Untriggered stop discards the window; advanced status visible
    advancedMode = 1;
    advFlags = 4'ha;
    advTrigState = 4'h5;
    depthLog2 = 4'h1;
    triggerPosition = 10'h0;
    run(0);
    repeat (2) @(negedge clk);
    check("advStatus", advStatus, 8'ha5);
    stopCmd = 1;
    @(negedge clk);
    stopCmd = 0;
    check("stopIdle", coreStatus, stIdle);
    // Two full windows plus a triggered partial one
    windowsLog2 = 4'h2;
    run(0);
    for (int k = 0; k < 3; k++) begin
      wait_state(stWaitTrigger);
      triggerHit = 1;
      @(negedge clk);
      triggerHit = 0;
    end
    stopCmd = 1;
    @(negedge clk);
    stopCmd = 0;
    check("stopFull", coreStatus, stFull);
    check("stopWindows", uploadWindows, 11'h3);
    wait_state(stIdle);
    check("stopWords", wordCount, 16'h5);
    clear_host();
    // Self re-arm after upload, then stop re-arming
    windowsLog2 = 4'h0;
    automatic_rearm = 1;
    run(1);
    wait_state(stFull);
    while (coreStatus === stFull) @(negedge clk);
    check("rearm", coreStatus, stWaitTrigger);
    automatic_rearm = 0;
    wait_state(stIdle);
    check("rearmWords", wordCount, 16'h4);
    // Stop in pre-trigger, then reset in mid-capture
    depthLog2 = 4'h3;
    triggerPosition = 10'h4;
    for (int j = 0; j < 2; j++) begin
      run(0);
      repeat (2) @(negedge clk);
      check("preSamples", captureStatus.totalSamples, 11'h2);
      stopCmd = j == 0;
      rst = j == 1;
      @(negedge clk);
      stopCmd = 0;
      rst = 0;
      check("haltIdle", coreStatus, stIdle);
      check("haltCounts", captureStatus, 32'h0);
    end
    check("haltValid", uploadValid, 1'b0);
    final_report();
  end
endmodule : test_logic_analyzer_capture_engine
